// file: design/low_power_wake_sequencer.sv
// wake sequencer for modem and controller low power states
`timescale 1ns/100ps
`include "wake_seq_defs.svh"
module low_power_wake_sequencer
  import wake_seq_pkg::*;
#(
  parameter int unsigned OFF_WAKE_CYC  = `US2CYC_DN(`OFF_WAKE_US),
  parameter int unsigned HIB_WAKE_CYC  = `US2CYC_DN(`HIB_WAKE_US),
  parameter int unsigned XTAL_LOCK_CYC = `US2CYC_DN(`XTAL_LOCK_US),
  parameter int unsigned XTAL_COLD_CYC = `US2CYC_DN(`XTAL_COLD_US),
  parameter int unsigned DOZE_TMR_CYC  = 32'd20000
) (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // pins from outside
  input  wire logic        modem_reset_n,
  input  wire logic        attention_wake_n,
  input  wire logic        mcu_reset_req,
  // modem side outputs
  output logic             modem_clock_out,
  output logic             attention_wake_n_irq,
  output logic             timer_irq,
  output logic             modem_idle,
  // controller side outputs
  output logic             mcu_running,
  output logic             bus_clk_internal,
  output logic             ext_ref_enable,
  output logic             rti_on_ext_clock
);

  // synchronisers for outside pins
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      // idle levels of the pins: no false controller reset after rstn
      sync1_q <= 3'h3;
      sync2_q <= 3'h3;
    end else if (clk_en) begin
      sync1_q <= {mcu_reset_req, attention_wake_n, modem_reset_n};
      sync2_q <= sync1_q;
    end
  end
  wire rst_n_s  = sync2_q[0];
  wire attention_wake_n_n_s = sync2_q[1];
  wire mcu_rst_s = sync2_q[2];

  logic attention_wake_n_n_prev_q;
  logic rst_n_prev_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      attention_wake_n_n_prev_q <= 1'b1;
      rst_n_prev_q  <= 1'b1;
    end else if (clk_en) begin
      attention_wake_n_n_prev_q <= attention_wake_n_n_s;
      rst_n_prev_q  <= rst_n_s;
    end
  end
  wire attention_wake_n_fall = attention_wake_n_n_prev_q & ~attention_wake_n_n_s;
  wire rst_rise  = ~rst_n_prev_q & rst_n_s;

  // registers
  logic [31:0] ctrl_q;
  logic [1:0]  modem_cmd_q;
  logic [1:0]  mcu_cmd_q;
  logic [7:0]  modem_clock_out_div_q;

  // ahb decode
  logic       dph_wr_q;
  logic [7:0] dph_addr_q;
  wire addr_phase = hsel & hready & htrans[1];
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dph_wr_q   <= 1'b0;
      dph_addr_q <= 8'h00;
    end else if (clk_en) begin
      dph_wr_q   <= addr_phase & hwrite;
      dph_addr_q <= haddr;
    end
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire wr_ctrl  = dph_wr_q & hit(dph_addr_q, `REG_CTRL);
  wire wr_mcmd  = dph_wr_q & hit(dph_addr_q, `REG_MODEM_CMD);
  wire wr_ccmd  = dph_wr_q & hit(dph_addr_q, `REG_MCU_CMD);

  modem_state_t mstate_q;
  mcu_state_t   cstate_q;
  wake_cause_t  cause_q;
  logic [31:0]  mcnt_q;
  logic [31:0]  ccnt_q;
  logic [7:0]   pdcnt_q;
  logic         modem_clock_out_q;
  logic [7:0]   modem_clock_out_cnt_q;
  logic         attention_wake_n_irq_q;
  logic         timer_irq_q;

  wire [31:0] status_w = {16'h0000, 2'b00, cause_q, 1'b0, cstate_q, 5'h00, mstate_q};
  // read data latched at the address phase so it stands in the zero-wait data phase
  wire [31:0] rd_mux =
      hit(haddr, `REG_CTRL)      ? ctrl_q :
      hit(haddr, `REG_STATUS)    ? status_w :
      hit(haddr, `REG_MODEM_CMD) ? {30'h0, modem_cmd_q} :
      hit(haddr, `REG_MCU_CMD)   ? {30'h0, mcu_cmd_q} : 32'h0000_0000;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_q      <= `CTRL_RESET;
      hrdata      <= 32'h0000_0000;
    end else if (clk_en) begin
      if (wr_ctrl)
        ctrl_q <= hwdata;
      if (addr_phase & ~hwrite)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  wire attention_wake_n_en     = ctrl_q[`CTRL_ATTENTION_WAKE_N_IRQ_EN];
  wire modem_clock_out_en     = ctrl_q[`CTRL_MODEM_CLOCK_OUT_EN];
  wire modem_clock_out_doze   = ctrl_q[`CTRL_MODEM_CLOCK_OUT_IN_DOZE];
  wire osc_keep_running_in_stop = ctrl_q[`CTRL_OSC_KEEP];
  wire low_vdd     = ctrl_q[`CTRL_LOW_VDD];
  wire [7:0] div_w = ctrl_q[`CTRL_MODEM_CLOCK_OUT_DIV_LSB +: `CTRL_MODEM_CLOCK_OUT_DIV_W];

  // modem state machine
  wire pd_last   = (mstate_q == M_PWRDN) && (pdcnt_q == 8'h01);
  wire modem_clock_out_live = (mstate_q == M_IDLE) || (mstate_q == M_PWRDN) ||
                   ((mstate_q == M_DOZE) && modem_clock_out_doze);
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mstate_q    <= M_OFF;
      cause_q     <= W_NONE;
      mcnt_q      <= 32'h0;
      pdcnt_q     <= 8'h00;
      modem_cmd_q <= 2'h0;
      modem_clock_out_div_q  <= `MODEM_CLOCK_OUT_DIV_DEFAULT;
      attention_wake_n_irq_q  <= 1'b0;
      timer_irq_q <= 1'b0;
    end else if (clk_en) begin
      attention_wake_n_irq_q  <= 1'b0;
      timer_irq_q <= 1'b0;
      if (wr_mcmd)
        modem_cmd_q <= hwdata[1:0];
      if (!rst_n_s) begin
        mstate_q <= M_OFF;
      end else begin
        case (mstate_q)
          M_IDLE: if (modem_cmd_q != 2'h0) begin
            pdcnt_q     <= `PD_LAST_CYCLES;
            modem_cmd_q <= modem_cmd_q;
            mstate_q    <= M_PWRDN;
          end
          M_PWRDN: begin
            // attention in any cycle of power down is lost
            pdcnt_q <= pdcnt_q - 8'h01;
            if (pd_last) begin
              mcnt_q      <= 32'h0;
              mstate_q    <= (modem_cmd_q == `CMD_MODEM_HIB) ? M_HIB : M_DOZE;
              modem_cmd_q <= 2'h0;
            end
          end
          M_OFF: if (rst_rise) begin
            cause_q    <= W_RESET;
            modem_clock_out_div_q <= `MODEM_CLOCK_OUT_DIV_DEFAULT;
            mcnt_q     <= OFF_WAKE_CYC - 32'd1;
            mstate_q   <= M_WAKE;
          end
          M_HIB: if (attention_wake_n_fall) begin
            cause_q  <= W_ATTENTION_WAKE_N;
            mcnt_q   <= HIB_WAKE_CYC - 32'd1;
            mstate_q <= M_WAKE;
          end
          M_DOZE: begin
            mcnt_q <= mcnt_q + 32'd1;
            if (attention_wake_n_fall || mcnt_q >= DOZE_TMR_CYC - 32'd1) begin
              cause_q  <= attention_wake_n_fall ? W_ATTENTION_WAKE_N : W_TIMER;
              mcnt_q   <= 32'(`DOZE_WAKE_CYC) + {23'h0, modem_clock_out_div_q, 1'b0} - 32'd1;
              mstate_q <= M_WAKE;
            end
          end
          M_WAKE: begin
            // extra attention edges are ignored here
            mcnt_q <= mcnt_q - 32'd1;
            if (mcnt_q == 32'd0) begin
              mstate_q <= M_IDLE;
              attention_wake_n_irq_q  <= (cause_q == W_RESET) ||
                             ((cause_q == W_ATTENTION_WAKE_N) && attention_wake_n_en);
              timer_irq_q <= (cause_q == W_TIMER);
            end
          end
          default: mstate_q <= M_OFF;
        endcase
        if (mstate_q == M_IDLE)
          modem_clock_out_div_q <= div_w;  // held across hibernate
      end
    end
  end

  // clock output divider; runs in doze if asked
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      modem_clock_out_q     <= 1'b0;
      modem_clock_out_cnt_q <= 8'h00;
    end else if (clk_en) begin
      if (!(modem_clock_out_live && (modem_clock_out_en || mstate_q == M_PWRDN))) begin
        modem_clock_out_q     <= 1'b0;
        modem_clock_out_cnt_q <= 8'h00;
      end else if (modem_clock_out_cnt_q >= modem_clock_out_div_q) begin
        modem_clock_out_q     <= ~modem_clock_out_q;
        modem_clock_out_cnt_q <= 8'h00;
      end else begin
        modem_clock_out_cnt_q <= modem_clock_out_cnt_q + 8'h01;
      end
    end
  end

  // controller stop recovery
  wire lock_fast = osc_keep_running_in_stop;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cstate_q  <= C_RUN;
      ccnt_q    <= 32'h0;
      mcu_cmd_q <= 2'h0;
    end else if (clk_en) begin
      if (wr_ccmd)
        mcu_cmd_q <= hwdata[1:0];
      case (cstate_q)
        C_RUN: begin
          // wake timer starts from zero on every stop entry
          ccnt_q <= 32'h0;
          if (mcu_cmd_q == `CMD_MCU_DEEP) begin
            cstate_q  <= C_DEEP;
            mcu_cmd_q <= 2'h0;
          end else if (mcu_cmd_q == `CMD_MCU_LIGHT) begin
            cstate_q  <= C_LIGHT;
            mcu_cmd_q <= 2'h0;
          end
        end
        C_DEEP: begin
          ccnt_q <= ccnt_q + 32'd1;
          // modem irq, reset or periodic timer
          if (attention_wake_n_irq_q || timer_irq_q || mcu_rst_s || ccnt_q >= DOZE_TMR_CYC) begin
            ccnt_q   <= (low_vdd ? 32'(`DEEP_REG_2V_CYC)
                                 : 32'(`DEEP_REG_3V_CYC)) - 32'd1;
            cstate_q <= C_REG_WAIT;
          end
        end
        C_LIGHT: begin
          ccnt_q <= ccnt_q + 32'd1;
          if (attention_wake_n_irq_q || timer_irq_q || mcu_rst_s || ccnt_q >= DOZE_TMR_CYC) begin
            ccnt_q   <= 32'(`LIGHT_MIN_CYC) - 32'd1;
            cstate_q <= C_REG_WAIT;
          end
        end
        C_REG_WAIT: begin
          ccnt_q <= ccnt_q - 32'd1;
          if (ccnt_q == 32'd0) begin
            // lock time depends on whether the oscillator kept running
            ccnt_q   <= lock_fast ? XTAL_LOCK_CYC - 32'd1 : XTAL_COLD_CYC - 32'd1;
            cstate_q <= C_LOCK_WAIT;
          end
        end
        C_LOCK_WAIT: begin
          ccnt_q <= ccnt_q - 32'd1;
          if (ccnt_q == 32'd0 && (modem_clock_out_live || lock_fast || !modem_clock_out_en))
            cstate_q <= C_RUN;
        end
        default: cstate_q <= C_RUN;
      endcase
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      modem_clock_out  <= 1'b0;
      attention_wake_n_irq         <= 1'b0;
      timer_irq        <= 1'b0;
      modem_idle       <= 1'b0;
      mcu_running      <= 1'b1;
      bus_clk_internal <= 1'b1;
      ext_ref_enable   <= 1'b0;
      rti_on_ext_clock <= 1'b0;
    end else if (clk_en) begin
      modem_clock_out  <= modem_clock_out_q;
      attention_wake_n_irq         <= attention_wake_n_irq_q;
      timer_irq        <= timer_irq_q;
      modem_idle       <= (mstate_q == M_IDLE);
      mcu_running      <= (cstate_q == C_RUN) || (cstate_q == C_LOCK_WAIT);
      bus_clk_internal <= (cstate_q != C_RUN);
      // no reference unless the modem clock state is live (idle, power down, or doze with clock kept); clock enable is not checked
      ext_ref_enable   <= osc_keep_running_in_stop && modem_clock_out_live;
      rti_on_ext_clock <= osc_keep_running_in_stop && modem_clock_out_live && modem_clock_out_doze;
    end
  end

endmodule

// file: design/wake_seq_defs.svh
// timing counts and field positions for the wake sequencer
`ifndef WAKE_SEQ_DEFS_SVH
`define WAKE_SEQ_DEFS_SVH

`define CLK_HZ              20000000
// recovery times in microseconds, as documented
`define OFF_WAKE_US         25000
`define HIB_WAKE_US         20000
`define DOZE_WAKE_US        300
`define DEEP_REG_3V_US      50
`define DEEP_REG_2V_US      80
`define LIGHT_MIN_US        100
`define XTAL_LOCK_US        2400
`define XTAL_COLD_US        180000
// cycle counts derived from the clock rate (US2CYC_DN and US2CYC_UP are the same whole-MHz multiply, no rounding)
`define US2CYC_DN(u)        (((u) * (`CLK_HZ / 1000000)))
`define US2CYC_UP(u)        (((u) * (`CLK_HZ / 1000000)))
`define DOZE_WAKE_CYC       `US2CYC_DN(`DOZE_WAKE_US)
`define DEEP_REG_3V_CYC     `US2CYC_UP(`DEEP_REG_3V_US)
`define DEEP_REG_2V_CYC     `US2CYC_UP(`DEEP_REG_2V_US)
`define LIGHT_MIN_CYC       `US2CYC_UP(`LIGHT_MIN_US)

// register byte offsets
`define REG_CTRL            8'h00
`define REG_STATUS          8'h04
`define REG_MODEM_CMD       8'h08
`define REG_MCU_CMD         8'h0C

// ctrl field positions
`define CTRL_ATTENTION_WAKE_N_IRQ_EN    0
`define CTRL_MODEM_CLOCK_OUT_EN        1
`define CTRL_MODEM_CLOCK_OUT_IN_DOZE   2
`define CTRL_OSC_KEEP       3
`define CTRL_LOW_VDD        4
`define CTRL_MODEM_CLOCK_OUT_DIV_LSB   8
`define CTRL_MODEM_CLOCK_OUT_DIV_W     8
`define CTRL_RESET          32'h0000_0003
`define MODEM_CLOCK_OUT_DIV_DEFAULT    8'hFF

// command codes and power-down cycle count
`define CMD_MODEM_HIB       2'h1
`define CMD_MODEM_DOZE      2'h2
`define CMD_MCU_DEEP        2'h1
`define CMD_MCU_LIGHT       2'h2
`define PD_LAST_CYCLES      8'h80

`endif

// file: design/wake_seq_pkg.sv
// types for the wake sequencer
package wake_seq_pkg;
  typedef enum logic [2:0] {
    M_IDLE, M_PWRDN, M_OFF, M_HIB, M_DOZE, M_WAKE
  } modem_state_t;
  typedef enum logic [2:0] {
    C_RUN, C_DEEP, C_LIGHT, C_REG_WAIT, C_LOCK_WAIT
  } mcu_state_t;
  typedef enum logic [1:0] {
    W_NONE, W_RESET, W_ATTENTION_WAKE_N, W_TIMER
  } wake_cause_t;
endpackage

// file: tb/wake_seq_properties.sv
// port assertions for the wake sequencer
`timescale 1ns/100ps
module wake_seq_properties #(
  parameter int unsigned OFF_WAKE_CYC = 50
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // modem pins and outputs
  input wire logic modem_reset_n,
  input wire logic modem_clock_out,
  input wire logic attention_wake_n_irq,
  input wire logic timer_irq,
  input wire logic modem_idle,
  // controller outputs
  input wire logic ext_ref_enable
);
  // slack covers the pin synchronisers
  localparam int OFF_LIM = OFF_WAKE_CYC + 10;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_attention_wake_n_single_pulse: assert property (attention_wake_n_irq |=> !attention_wake_n_irq)
    else $error("attention irq longer than one cycle");
  a_timer_single_pulse: assert property (timer_irq |=> !timer_irq)
    else $error("timer irq longer than one cycle");
  a_irq_at_idle: assert property ((attention_wake_n_irq || timer_irq) |-> ##[0:1] modem_idle)
    else $error("wake irq without idle");
  a_irq_kinds_apart: assert property (!(attention_wake_n_irq && timer_irq))
    else $error("both wake irqs at once");
  a_off_not_idle: assert property (!modem_reset_n [*4] |-> !modem_idle)
    else $error("idle while held off");
  a_off_clock_still: assert property (!modem_reset_n [*4] |-> $stable(modem_clock_out))
    else $error("clock output runs while off");
  a_off_ref_closed: assert property (!modem_reset_n [*4] |-> !ext_ref_enable)
    else $error("external reference on while modem off");
  a_off_wake_bound: assert property ($rose(modem_reset_n) |-> ##[1:OFF_LIM] attention_wake_n_irq)
    else $error("no irq after release from off");
endmodule

bind low_power_wake_sequencer wake_seq_properties #(.OFF_WAKE_CYC(OFF_WAKE_CYC)) chk_i (
  .clk_sys         (clk_sys),
  .rstn            (rstn),
  .modem_reset_n   (modem_reset_n),
  .modem_clock_out (modem_clock_out),
  .attention_wake_n_irq        (attention_wake_n_irq),
  .timer_irq       (timer_irq),
  .modem_idle      (modem_idle),
  .ext_ref_enable  (ext_ref_enable)
);

// file: tb/host_model.sv
// host controller pins that wake the modem and the controller
`timescale 1ns/100ps
module host_model (
  // clock
  input wire logic clk_sys,
  // pins
  output logic     modem_reset_n,
  output logic     attention_wake_n,
  output logic     mcu_reset_req
);
  // modem held off until the bench releases it
  initial begin
    modem_reset_n = 1'b0;
    attention_wake_n = 1'b1;
    mcu_reset_req = 1'b0;
  end
  task release_modem;
    @(posedge clk_sys);
    modem_reset_n <= 1'b1;
  endtask
  // k 0 attention, 1 controller reset; pulse of 4 cycles
  task pulse(input int k);
    @(posedge clk_sys);
    if (k == 0) attention_wake_n <= 1'b0;
    else mcu_reset_req <= 1'b1;
    repeat (4) @(posedge clk_sys);
    attention_wake_n <= 1'b1;
    mcu_reset_req <= 1'b0;
  endtask
endmodule

// file: tb/tb.sv
// bench for the wake sequencer
`timescale 1ns/100ps
`include "wake_seq_defs.svh"
module tb;
  import wake_seq_pkg::*;
  logic        clk_sys, rstn, hsel, hwrite, hreadyout, modem_reset_n, attention_wake_n;
  logic        mcu_reset_req, modem_clock_out, attention_wake_n_irq, timer_irq, modem_idle, v;
  logic        mcu_running, bus_clk_internal, ext_ref_enable, clk_en, hresp, rti_on_ext_clock;
  logic [2:0]  hsize;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, q;
  int          miscompares, num_checks, attention_wake_n_cnt, n, c0;
  logic [31:0] cfg [3] = '{32'h3, 32'h13, 32'hB};
  int          lo [3] = '{1000, 1600, 2000};

  low_power_wake_sequencer #(.OFF_WAKE_CYC(50), .HIB_WAKE_CYC(40), .XTAL_LOCK_CYC(20),
    .XTAL_COLD_CYC(30), .DOZE_TMR_CYC(100)) low_power_wake_sequencer_i (
    .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .modem_reset_n(modem_reset_n),
    .attention_wake_n(attention_wake_n), .mcu_reset_req(mcu_reset_req),
    .modem_clock_out(modem_clock_out), .attention_wake_n_irq(attention_wake_n_irq), .timer_irq(timer_irq),
    .modem_idle(modem_idle), .mcu_running(mcu_running), .bus_clk_internal(bus_clk_internal),
    .ext_ref_enable(ext_ref_enable), .rti_on_ext_clock(rti_on_ext_clock));
  host_model host_model_i (.clk_sys(clk_sys), .modem_reset_n(modem_reset_n),
    .attention_wake_n(attention_wake_n), .mcu_reset_req(mcu_reset_req));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (attention_wake_n_irq === 1'b1) attention_wake_n_cnt <= attention_wake_n_cnt + 1;

  task close_out;
    if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // k 0 attention_wake_n irq, 1 timer irq, 2 running, 3 idle; a spent bound ends the run
  task wf(input int k, input int lim, output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (!(k == 0 ? attention_wake_n_irq === 1'b1 : k == 1 ? timer_irq === 1'b1 :
                 k == 2 ? mcu_running === 1'b1 : modem_idle === 1'b1) && c < lim);
    if (c >= lim) begin
      miscompares++;
      close_out;
    end
  endtask
  // edges until the clock output changes, 8 at most
  task tog(output int c);
    logic v0;
    v0 = modem_clock_out;
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (modem_clock_out === v0 && c < 8);
  endtask
  task rdy;
    int c;
    c = 0;
    do begin
      @(posedge clk_sys);
      c++;
    end while (hreadyout !== 1'b1 && c < 20);
    if (c >= 20) begin
      miscompares++;
      close_out;
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= a;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
  endtask
  task enter(input logic [31:0] ctrl, input logic [31:0] cmd);
    bus(1'b1, `REG_CTRL, ctrl);
    bus(1'b1, `REG_MODEM_CMD, cmd);
    repeat (200) @(posedge clk_sys);
  endtask

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwdata = 32'h0;
    hsize = 3'h2;
    clk_en = 1'b1;
    attention_wake_n_cnt = 0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    bus(1'b0, `REG_CTRL, 32'h0);
    chk("ctrl reset", q, `CTRL_RESET);
    chk("okay", hresp, 1'b0);
    bus(1'b1, 8'h10, 32'hFFFF_FFFF);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", q, 32'h0);
    chk("ref off", ext_ref_enable, 1'b0);
    host_model_i.release_modem();
    wf(0, 70, n);
    chk("off wake", n >= 50 && n <= 60, 1'b1);
    tog(n);
    chk("clock live", n < 8, 1'b1);
    enter(32'h2, `CMD_MODEM_HIB);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("hib", q[2:0], M_HIB);
    c0 = attention_wake_n_cnt;
    host_model_i.pulse(0);
    wf(3, 60, n);
    repeat (4) @(posedge clk_sys);
    chk("masked irq", attention_wake_n_cnt - c0, 0);
    enter(32'h3, `CMD_MODEM_HIB);
    c0 = attention_wake_n_cnt;
    host_model_i.pulse(0);
    host_model_i.pulse(0);
    wf(0, 60, n);
    chk("hib wake", n + 10 >= 40 && n + 10 <= 50, 1'b1);
    repeat (60) @(posedge clk_sys);
    chk("one irq", attention_wake_n_cnt - c0, 1);
    bus(1'b1, `REG_MODEM_CMD, `CMD_MODEM_HIB);
    repeat (100) @(posedge clk_sys);
    host_model_i.pulse(0);
    repeat (300) @(posedge clk_sys);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("late attention_wake_n", q[2:0], M_HIB);
    host_model_i.pulse(0);
    wf(0, 60, n);
    enter(32'h3, `CMD_MODEM_DOZE);
    v = modem_clock_out;
    repeat (3) @(posedge clk_sys);
    chk("doze still", modem_clock_out, v);
    host_model_i.pulse(0);
    wf(0, 6100, n);
    chk("doze wake", n + 5 >= 6000 && n <= 6012, 1'b1);
    enter(32'h7, `CMD_MODEM_DOZE);
    tog(n);
    chk("doze clock", n < 8, 1'b1);
    c0 = attention_wake_n_cnt;
    wf(1, 6300, n);
    chk("timer exit", attention_wake_n_cnt - c0, 0);
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, `REG_CTRL, cfg[i]);
      bus(1'b1, `REG_MCU_CMD, i == 2 ? `CMD_MCU_LIGHT : `CMD_MCU_DEEP);
      repeat (4) @(posedge clk_sys);
      chk("stopped", mcu_running, 1'b0);
      host_model_i.pulse(1);
      wf(2, 3000, n);
      chk("recovery", n + 5 >= lo[i] && n <= lo[i] + 60, 1'b1);
      chk("internal clk", bus_clk_internal, 1'b1);
      repeat (40) @(posedge clk_sys);
    end
    bus(1'b1, `REG_CTRL, 32'hF);
    repeat (3) @(posedge clk_sys);
    chk("rti ext", rti_on_ext_clock, 1'b1);
    chk("ref on", ext_ref_enable, 1'b1);
    clk_en <= 1'b0;
    @(posedge clk_sys);
    v = modem_clock_out;
    repeat (3) @(posedge clk_sys);
    chk("frozen", modem_clock_out, v);
    clk_en <= 1'b1;
    close_out;
  end
endmodule
